// ---- src/tmw_pkg.sv ----
// Package of constants and types for the 8-bit waveform timer
`default_nettype none
package tmw_pkg;
   localparam int          CNT_W         = 8;        // Counter width
   localparam logic [7:0]  CNT_BOTTOM    = 8'h00;    // Bottom of the count
   localparam logic [7:0]  CNT_MAX       = 8'hFF;    // Maximum of the count
   localparam logic [7:0]  CNT_RESET     = 8'h00;    // Counter value after reset
   localparam logic [7:0]  CMP_RESET     = 8'h00;    // Compare value after reset
   localparam logic [1:0]  MODE_NORMAL   = 2'h0;     // Free running up count
   localparam logic [1:0]  MODE_PHASE    = 2'h1;     // Phase correct PWM, not served here
   localparam logic [1:0]  MODE_CLEAR    = 2'h2;     // Clear-on-match mode
   localparam logic [1:0]  MODE_FAST     = 2'h3;     // Fast PWM
   localparam logic [1:0]  ACT_NONE      = 2'h0;     // No action at match
   localparam logic [1:0]  ACT_TOGGLE    = 2'h1;     // Toggle at match
   localparam logic [1:0]  ACT_CLEAR     = 2'h2;     // Clear at match
   localparam logic [1:0]  ACT_SET       = 2'h3;     // Set at match
   localparam int          PRE_W         = 10;       // Prescale counter width
   localparam logic [9:0]  PRE_RESET     = 10'h000;  // Prescale count after reset
   // Clock select codes
   typedef enum logic [2:0] {
      CS_STOP, CS_DIV1, CS_DIV8, CS_DIV32, CS_DIV64, CS_DIV128, CS_DIV256, CS_DIV1024
   } tmw_clksel_type;
endpackage : tmw_pkg
`default_nettype wire

// ---- src/tmw_prescaler.sv ----
// Prescaler that makes the timer clock enable from the I/O clock
`default_nettype none
module tmw_prescaler
   import tmw_pkg::*;
(
   input  wire logic            ref_clk,          // I/O clock
   input  wire logic            rst,              // Asynchronous reset, active high
   input  wire logic [2:0]      clock_select_field, // Prescale choice
   output logic                 tick              // One-cycle timer clock enable
);
   logic [PRE_W-1:0] pre_reg;  // Free running divide counter
   logic [PRE_W-1:0] pre_next; // Next divide count
   logic [PRE_W-1:0] mask;     // Low bits that must all be one for a tick

   // Mask picks the division ratio from the select code
   always_comb begin
      unique case (clock_select_field)
         CS_STOP:    mask = 10'h000;
         CS_DIV1:    mask = 10'h000;
         CS_DIV8:    mask = 10'h007;
         CS_DIV32:   mask = 10'h01F;
         CS_DIV64:   mask = 10'h03F;
         CS_DIV128:  mask = 10'h07F;
         CS_DIV256:  mask = 10'h0FF;
         default:    mask = 10'h3FF;
      endcase
   end

   assign pre_next = pre_reg + 10'h001;
   // Stopped timer gives no tick at all
   assign tick = (clock_select_field != CS_STOP) && ((pre_reg & mask) == mask); // R20

   // Divider runs always; a shared counter keeps ratios aligned
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pre_reg <= PRE_RESET;
      end else begin
         pre_reg <= pre_next;
      end
   end
endmodule : tmw_prescaler
`default_nettype wire

// ---- src/tmw_timer.sv ----
// 8-bit timer with one compare channel: normal, clear-on-match and fast PWM
// Functional notes
// R01: Nonzero action field overrides port output value
// R02: Waveform shows on pin only when output
// R03: Override ignores the waveform mode
// R04: Action zero leaves waveform bit unchanged
// R05: Action change acts next match; force immediate
// R06: Count sequence depends only on mode
// R07: Mode zero increments and wraps FF to 00
// R08: Normal mode sets overflow when count hits zero
// R09: Overflow flag cleared when its interrupt runs
// R10: Mode two clears counter at compare match
// R11: Clear-on-match compare writes unbuffered, may wrap
// R12: Clear-on-match sets compare flag at top
// R13: Clear-on-match toggle action toggles each match
// R14: Clear-on-match overflow at MAX to zero
// R15: Mode three counts zero to MAX, 256 states
// R16: Fast PWM: action two/three clear/set polarity
// R17: Fast PWM overflow flag set at MAX
// R18: Fast PWM extreme compare values give spike/constant
// R19: Fast PWM toggle action, compare buffered
// R20: Timer clock is prescaled I/O clock
// R21: Match sets compare flag next timer cycle
// R22: PWM compare writes buffered until bottom
// R23: Counter write blocks next match, wins
// R24: Force updates output without flag or clear
// R25: Waveform bit resets zero, holds across modes
// R26: Everything steps only on timer clock enable; code takes processor writes, flag clears and force on any I/O clock
`default_nettype none
module tmw_timer
   import tmw_pkg::*;
(
   input  wire logic                  ref_clk,              // I/O clock
   input  wire logic                  rst,                  // Asynchronous reset, active high
   input  wire logic [2:0]            clock_select_field,   // Prescale select, zero stops
   input  wire logic [1:0]            wave_mode_field,      // Counting mode
   input  wire logic [1:0]            compare_action_field, // Output action
   input  wire logic                  force_compare_strobe, // One-cycle force pulse
   input  wire logic                  count_write,          // Processor write to counter
   input  wire logic [CNT_W-1:0]      count_write_data,     // Value for counter write
   input  wire logic                  compare_write,        // Processor write to compare value
   input  wire logic [CNT_W-1:0]      compare_write_data,   // Value for compare write
   input  wire logic                  overflow_flag_clear,  // Write one or vector taken
   input  wire logic                  compare_flag_clear,   // Write one or vector taken
   input  wire logic                  port_out_value,       // General port output bit
   input  wire logic                  wave_pin_direction,   // One selects output
   output logic [CNT_W-1:0]           count_value,          // Current count
   output logic [CNT_W-1:0]           compare_value,        // Active compare value
   output logic                       overflow_flag,        // Sticky overflow
   output logic                       compare_flag,         // Sticky compare match
   output logic                       wave_out_bit,         // Internal waveform state
   output logic                       wave_pin_out,         // Pin output level
   output logic                       wave_pin_oe           // Pin output enable
);
   logic [CNT_W-1:0] cnt_reg;        // Counter
   logic [CNT_W-1:0] cnt_next;       // Counter next value
   logic [CNT_W-1:0] cmp_reg;        // Active compare value
   logic [CNT_W-1:0] cmp_next;       // Active compare next value
   logic [CNT_W-1:0] cmp_buf_reg;    // Buffer for PWM writes
   logic [CNT_W-1:0] cmp_buf_next;   // Buffer next value
   logic             ovf_reg;        // Overflow flag
   logic             ovf_next;       // Overflow flag next
   logic             cf_reg;         // Compare flag
   logic             cf_next;        // Compare flag next
   logic             match_pend_reg; // Match seen, flag due on next tick
   logic             match_pend_next;// Pending match next
   logic             block_reg;      // Counter write blocks next tick's match
   logic             block_next;     // Block next
   logic             wave_reg;       // Waveform bit
   logic             wave_next;      // Waveform next
   logic             tick;           // Timer clock enable
   logic             pwm_mode;       // Fast or phase PWM selected
   logic             raw_match;      // Comparator equality
   logic             match;          // Match honoured this tick
   logic             at_max;         // Counter at MAX
   logic             wrap;           // Counter goes to zero this tick
   logic             forced;         // Force strobe effective
   logic             wave_act;       // Waveform value after a match action

   // Timer clock enable from the divider
   tmw_prescaler u_pre (
      .ref_clk            (ref_clk),
      .rst                (rst),
      .clock_select_field (clock_select_field),
      .tick               (tick)
   );

   // Decode of modes and events
   assign pwm_mode  = wave_mode_field[0];
   assign at_max    = (cnt_reg == CNT_MAX);
   assign raw_match = (cnt_reg == cmp_reg);
   // A counter write blocks the match on the following timer cycle
   assign match     = tick && raw_match && !block_reg && !count_write; // R23 R26
   // Counter reaches bottom by wrap or by match clear in clear-on-match
   assign wrap      = tick && (at_max || (wave_mode_field == MODE_CLEAR && match));
   assign forced    = force_compare_strobe && !pwm_mode; // R05 R24

   // Counter: write wins, otherwise mode decides; action field never used here
   always_comb begin
      cnt_next = cnt_reg;
      if (count_write) begin
         cnt_next = count_write_data; // R23
      end else if (tick) begin
         if (wave_mode_field == MODE_CLEAR && match) begin
            cnt_next = CNT_BOTTOM; // R10
         end else begin
            cnt_next = cnt_reg + 8'h01; // R06 R07 R15 R11
         end
      end
   end

   // Compare value: direct in non-PWM, buffered and loaded at MAX-to-bottom in PWM
   assign cmp_buf_next = compare_write ? compare_write_data : cmp_buf_reg; // R22
   always_comb begin
      cmp_next = cmp_reg;
      if (!pwm_mode) begin
         if (compare_write) begin
            cmp_next = compare_write_data; // R11 R22
         end
      end else if (tick && at_max) begin
         cmp_next = cmp_buf_reg; // R19 R22
      end
   end

   // Waveform value produced by a real or forced match
   always_comb begin
      unique case (compare_action_field)
         ACT_NONE:   wave_act = wave_reg; // R04
         ACT_TOGGLE: wave_act = ~wave_reg; // R13 R19
         ACT_CLEAR:  wave_act = 1'b0;
         ACT_SET:    wave_act = 1'b1;
      endcase
   end

   // Waveform: match action first, fast PWM bottom action on the wrap tick only when there is no match
   always_comb begin
      wave_next = wave_reg; // R25
      if (forced || match) begin
         wave_next = wave_act; // R05 R24
      end
      // Bottom restore in fast PWM; a match at MAX wins, so MAX compare stays constant
      if (wave_mode_field == MODE_FAST && tick && at_max && !match) begin
         if (compare_action_field == ACT_CLEAR) begin
            wave_next = 1'b1; // R16 R18
         end else if (compare_action_field == ACT_SET) begin
            wave_next = 1'b0; // R16 R18
         end
      end
   end

   // Overflow flag: set beats clear, so no event is lost
   always_comb begin
      ovf_next = ovf_reg;
      if (overflow_flag_clear) begin
         ovf_next = 1'b0; // R09
      end
      if (wave_mode_field == MODE_FAST) begin
         if (tick && cnt_reg == 8'hFE && !count_write) begin
            ovf_next = 1'b1; // R17
         end
      end else if (tick && at_max && !count_write) begin
         ovf_next = 1'b1; // R08 R14
      end
   end

   // Compare flag lags the match by one timer cycle; force never sets it
   assign match_pend_next = tick ? match : match_pend_reg; // R21 R24
   always_comb begin
      cf_next = cf_reg;
      if (compare_flag_clear) begin
         cf_next = 1'b0; // R21
      end
      if (tick && match_pend_reg) begin
         cf_next = 1'b1; // R12 R21
      end
   end

   // Block lasts until the next timer tick, even if timer is stopped
   always_comb begin
      block_next = block_reg;
      if (count_write) begin
         block_next = 1'b1; // R23
      end else if (tick) begin
         block_next = 1'b0;
      end
   end

   // State registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_reg        <= CNT_RESET;
         cmp_reg        <= CMP_RESET;
         cmp_buf_reg    <= CMP_RESET;
         ovf_reg        <= 1'b0;
         cf_reg         <= 1'b0;
         match_pend_reg <= 1'b0;
         block_reg      <= 1'b0;
         wave_reg       <= 1'b0; // R25
      end else begin
         cnt_reg        <= cnt_next;
         cmp_reg        <= cmp_next;
         cmp_buf_reg    <= cmp_buf_next;
         ovf_reg        <= ovf_next;
         cf_reg         <= cf_next;
         match_pend_reg <= match_pend_next;
         block_reg      <= block_next;
         wave_reg       <= wave_next;
      end
   end

   // Pin mux: override by action field alone, direction bit gates the drive
   assign wave_pin_out = (compare_action_field != ACT_NONE) ? wave_reg : port_out_value; // R01 R03
   assign wave_pin_oe  = wave_pin_direction; // R02

   // Outputs straight from registers
   assign count_value   = cnt_reg;
   assign compare_value = cmp_reg;
   assign overflow_flag = ovf_reg;
   assign compare_flag  = cf_reg;
   assign wave_out_bit  = wave_reg;
endmodule : tmw_timer
`default_nettype wire

// ---- tb/tmw_timer_chk.sv ----
// Port checker for the 8-bit waveform timer
`default_nettype none
module tmw_timer_chk
   import tmw_pkg::*;
(
   input wire logic             ref_clk,
   input wire logic             rst,
   input wire logic [2:0]       clock_select_field,
   input wire logic [1:0]       wave_mode_field,
   input wire logic [1:0]       compare_action_field,
   input wire logic             count_write,
   input wire logic [CNT_W-1:0] count_write_data,
   input wire logic             port_out_value,
   input wire logic             wave_pin_direction,
   input wire logic [CNT_W-1:0] count_value,
   input wire logic [CNT_W-1:0] compare_value,
   input wire logic             overflow_flag,
   input wire logic             compare_flag,
   input wire logic             wave_out_bit,
   input wire logic             wave_pin_out,
   input wire logic             wave_pin_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Undivided timer clock with no counter write: every edge is a tick
   wire run_w = clock_select_field == 3'h1 && !count_write;
   // Real match in clear-on-match mode, not blocked by a write just before
   sequence s_match;
      run_w && wave_mode_field == MODE_CLEAR && count_value == compare_value && !$past(count_write);
   endsequence
   a_pin_override: assert property (wave_pin_out == (compare_action_field != ACT_NONE ?
      wave_out_bit : port_out_value)) else $error("pin source wrong");
   a_pin_enable: assert property (wave_pin_oe == wave_pin_direction) else $error("pin oe");
   a_count_load: assert property (count_write |=> count_value == $past(count_write_data))
      else $error("count load lost");
   a_normal_step: assert property (run_w && wave_mode_field == MODE_NORMAL |=>
      count_value == $past(count_value) + 8'h01) else $error("normal step");
   a_normal_ovf: assert property (run_w && wave_mode_field == MODE_NORMAL && count_value == CNT_MAX
      |=> overflow_flag && count_value == CNT_BOTTOM) else $error("normal overflow");
   a_ctc_clear: assert property (s_match |=> count_value == CNT_BOTTOM) else $error("no clear");
   a_ctc_flag: assert property (s_match |=> ##1 compare_flag) else $error("flag late");
   a_ctc_toggle: assert property (s_match ##0 compare_action_field == ACT_TOGGLE |=>
      wave_out_bit != $past(wave_out_bit)) else $error("no toggle");
   a_fast_top: assert property (run_w && wave_mode_field == MODE_FAST && count_value == 8'hFE
      |=> count_value == CNT_MAX && overflow_flag) else $error("fast top");
   a_fast_wrap: assert property (run_w && wave_mode_field == MODE_FAST && count_value == CNT_MAX
      |=> count_value == CNT_BOTTOM) else $error("fast wrap");
   a_act_none: assert property (compare_action_field == ACT_NONE |=> $stable(wave_out_bit))
      else $error("wave moved");
   a_stop_hold: assert property ($past(clock_select_field) == 3'h0 && clock_select_field == 3'h0
      && !count_write |=> $stable(count_value)) else $error("stopped count moved");
endmodule : tmw_timer_chk
bind tmw_timer tmw_timer_chk i_chk (.*);
`default_nettype wire

// ---- tb/tmw_timer_tb.sv ----
// Self-checking bench for the 8-bit waveform timer
`default_nettype none
module tmw_timer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import tmw_pkg::*;
   // Expected value: check cycle, watched output, value
   typedef struct {int c; int w; logic [7:0] e;} tmw_note_type;
   logic ref_clk, rst, frc, cw, kw, oclr, cclr, pov, dir;
   logic [2:0] cs;
   logic [1:0] mode, act;
   logic [7:0] cwd, kwd;
   wire logic [7:0] cnt, cmpv;
   wire logic ovf, cflg, wave, pout, poe;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] seed = 32'hC8BF;
   tmw_note_type q[$];
   string nm [5] = '{"count_value", "overflow_flag", "compare_flag", "wave_out_bit", "compare_value"};
   tmw_timer i_dut (.ref_clk(ref_clk), .rst(rst), .clock_select_field(cs), .wave_mode_field(mode),
      .compare_action_field(act), .force_compare_strobe(frc), .count_write(cw),
      .count_write_data(cwd), .compare_write(kw), .compare_write_data(kwd),
      .overflow_flag_clear(oclr), .compare_flag_clear(cclr), .port_out_value(pov),
      .wave_pin_direction(dir), .count_value(cnt), .compare_value(cmpv), .overflow_flag(ovf),
      .compare_flag(cflg), .wave_out_bit(wave), .wave_pin_out(pout), .wave_pin_oe(poe));
   // Xorshift source for the random phase
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   // Current value of a watched output
   function automatic logic [7:0] seen(input int w);
      case (w)
         0: return cnt;
         1: return {7'h00, ovf};
         2: return {7'h00, cflg};
         3: return {7'h00, wave};
         default: return cmpv;
      endcase
   endfunction : seen
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Driver steps always land 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step
   task automatic note(input int d, input int w, input logic [7:0] e);
      q.push_back('{cyc + d, w, e});
   endtask : note
   task automatic stop_test;
      if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   always @(posedge ref_clk) cyc <= cyc + 1;
   // Monitor on the falling edge, where registered outputs have settled
   always @(negedge ref_clk) begin
      while (q.size() > 0 && q[0].c <= cyc) begin
         num_checks++;
         if (seen(q[0].w) !== q[0].e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm[q[0].w], q[0].e, seen(q[0].w));
         end
         void'(q.pop_front());
      end
   end
   // Run takes about 560 cycles; 5000 means a hang
   initial begin
      #20000;
      err_total++;
      stop_test();
   end
   initial begin
      rst = 1'b1;
      cs = 3'h1;
      mode = MODE_NORMAL;
      act = ACT_NONE;
      {frc, cw, kw, oclr, cclr, pov, dir} = 7'h00;
      cwd = 8'h00;
      kwd = 8'h00;
      step(16);
      rst = 1'b0;
      step(2);
      // Normal wrap through the top value
      cw = 1'b1; cwd = 8'hFD; oclr = 1'b1;
      note(1, 0, 8'hFD);
      note(3, 0, 8'hFF); note(3, 1, 8'h00);
      note(4, 0, 8'h00); note(4, 1, 8'h01);
      step(1); cw = 1'b0; oclr = 1'b0; step(6);
      // Clear-on-match with toggle, top of three
      cw = 1'b1; cwd = 8'h00; kw = 1'b1; kwd = 8'h03; mode = MODE_CLEAR; act = ACT_TOGGLE; cclr = 1'b1;
      note(4, 0, 8'h03); note(5, 0, 8'h00);
      note(5, 2, 8'h00); note(5, 3, 8'h01); note(6, 2, 8'h01);
      note(9, 3, 8'h00);
      step(1); cw = 1'b0; kw = 1'b0; cclr = 1'b0; step(10);
      // Fast PWM, non-inverting, compare write held until the top
      cw = 1'b1; cwd = 8'h00; kw = 1'b1; kwd = 8'h10; mode = MODE_FAST; act = ACT_CLEAR; oclr = 1'b1;
      note(2, 4, 8'h03);
      note(256, 0, 8'hFF); note(256, 1, 8'h01);
      note(257, 3, 8'h01); note(257, 4, 8'h10); note(274, 3, 8'h00);
      step(1); cw = 1'b0; kw = 1'b0; oclr = 1'b0; step(280);
      // Force in normal mode: wave set, no flag, no clear
      cw = 1'b1; cwd = 8'h00; kw = 1'b1; kwd = 8'h80; mode = MODE_NORMAL; act = ACT_SET; cclr = 1'b1;
      step(1); cw = 1'b0; kw = 1'b0; cclr = 1'b0; frc = 1'b1;
      note(1, 3, 8'h01); note(2, 0, 8'h02); note(3, 2, 8'h00);
      step(1); frc = 1'b0; step(4);
      // Random pin levels, actions and counter loads
      repeat (200) begin
         seed = xs(seed);
         {pov, dir, act, cw} = seed[4:0];
         cwd = seed[15:8];
         step(1);
      end
      cw = 1'b0;
      // Stopped timer still takes a counter write and then holds
      cs = 3'h0; step(2); cw = 1'b1; cwd = 8'h5A;
      note(1, 0, 8'h5A); note(10, 0, 8'h5A);
      step(1); cw = 1'b0; step(12);
      // Divide by eight: any 16 cycles after a load hold exactly two ticks
      cs = 3'h2; cw = 1'b1; cwd = 8'h20;
      note(1, 0, 8'h20); note(17, 0, 8'h22);
      step(1); cw = 1'b0; step(20);
      stop_test();
   end
endmodule : tmw_timer_tb
`default_nettype wire
